//--- hdl/lin_sync_fault_monitor.sv
// lin sync acquisition, event flags, dominant timeouts and bus stuck/wake monitors
// What this block does
// - written bytes load divisor, rate clk/(div+1)
// - rate bytes read back acquired divisor
// - valid sync stores divisor, sets sync flag
// - auto update copies divisor, sets done flag
// - receive status set on start, cleared stop
// - loopback routes transmit back to receive
// - mismatch flag sticky, enable gates interrupt
// - abort options clear transmit or receive path
// - bus level bit mirrors receive pin
// - idle bit high when quiet or disabled
// - hardware sets flags, write one clears, mismatch write zero clears
// - break flag: sent as master, ended slave
// - counter overflow flag at all ones
// - global enable gates all event interrupts
// - narrow mode accepts six percent deviation
// - wide mode fifty percent, break limits
// - sync valid updated in wide mode
// - polarity bit inverts transmit output
// - transmit dominant timeout limit plus one
// - seventeen bit receive dominant timeout
// - fault may force break state exit
// - slow oscillator stuck and wake timing
// - role bit changes only while disabled
// - one shot update clears itself after use
//
// Strobed register access is this design's own decision.
module lin_sync_fault_monitor
   import lin_sync_pkg::*;
(
   input wire logic CORE_CLK,
   input wire logic SYS_RST,
   input wire logic [15:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR_EN,
   input wire logic RD_EN,
   output logic [7:0] RDATA,
   input wire logic RXD_PIN,
   input wire logic TX_BIT,
   input wire logic TX_ACTIVE,
   input wire logic RX_START,
   input wire logic RX_STOP,
   input wire logic BREAK_SENT,
   input wire logic COUNTER_ALL_ONES,
   input wire logic FAST_TICK,
   input wire logic SLOW_TICK,
   output logic TXD_PIN,
   output logic RX_LINE,
   output logic [15:0] RATE_DIVISOR,
   output logic TX_ABORT,
   output logic RX_ABORT,
   output logic BREAK_EXIT,
   output logic MASTER_MODE,
   output logic BUS_IRQ,
   output logic FAULT_IRQ,
   output logic WAKE_IRQ
);
   import lin_sync_pkg::*;

   typedef enum logic [3:0] {
      S_IDLE = 4'b0001,
      S_BREAK = 4'b0010,
      S_SYNC = 4'b0100,
      S_DONE = 4'b1000
   } sync_state_type;

   // synchroniser on the receive pin
   logic rx_meta_q;
   logic rx_pin_q;
   // pin level and prior level for edge detection
   logic rx_prev_q;
   // register contents
   logic [7:0] ctrl_q;
   logic [15:0] rate_divisor_q;
   logic [15:0] acquired_rate_divisor_q;
   logic [7:0] flags_q;
   logic [7:0] enables_q;
   logic sync_valid_q;
   logic [7:0] tcfg_q;
   logic [15:0] tx_dominant_limit_q;
   logic [15:0] rx_dominant_hi_q;
   logic [15:0] stuck_clear_width_q;
   logic [7:0] stuck_active_width_q;
   logic [7:0] swake_q;
   logic loopback_enable_q;
   logic mismatch_abort_tx_q;
   logic mismatch_abort_rx_q;
   logic receive_in_progress_q;
   logic [7:0] rdata_q;
   // sync measurement
   sync_state_type state_q;
   logic [17:0] brk_cnt_q;
   logic [19:0] sync_cnt_q;
   logic [2:0] edge_cnt_q;
   // timeout counters
   logic [16:0] tx_dom_cnt_q;
   logic [16:0] rx_dom_cnt_q;
   logic [15:0] stuck_cnt_q;
   logic [3:0] wake_cnt_q;
   logic stuck_q;

   logic rx_line;
   logic tx_line;
   logic mismatch_set;
   logic sync_ok;
   logic sync_commit;
   logic slave_break_end;
   logic tx_fault_set;
   logic rx_fault_set;
   logic [15:0] measured;
   logic [16:0] rx_dominant_limit;
   logic [17:0] tol_span;

   // address match on a write strobe
   function automatic logic wr_at(input logic [15:0] a);
      wr_at = WR_EN && (ADDR == a);
   endfunction

   // two flop synchroniser for the receive pin
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         rx_meta_q <= 1'b1;
         rx_pin_q <= 1'b1;
      end else begin
         rx_meta_q <= RXD_PIN;
         rx_pin_q <= rx_meta_q;
      end
   end

   // loopback picks the internal transmit level as receive input
   assign tx_line = TX_BIT;
   assign rx_line = loopback_enable_q ? tx_line : rx_pin_q;
   assign RX_LINE = rx_line;
   // pin stays driven in loopback; the pin mux outside can release it
   assign TXD_PIN = tx_line ^ enables_q[POL_BIT];
   assign RATE_DIVISOR = rate_divisor_q;
   assign MASTER_MODE = ctrl_q[ROLE_BIT];
   assign rx_dominant_limit = {rx_dominant_hi_q, tcfg_q[RXLIM0_BIT]};

   // previous line level
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         rx_prev_q <= 1'b1;
      end else begin
         rx_prev_q <= rx_line;
      end
   end

   // control register; role changes only while disabled
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         ctrl_q <= RESET_BYTE;
      end else if (wr_at(CONTROL_ADDR)) begin
         ctrl_q[EN_BIT] <= WDATA[EN_BIT];
         ctrl_q[AUTO_BIT] <= WDATA[AUTO_BIT];
         ctrl_q[ONESHOT_BIT] <= WDATA[ONESHOT_BIT];
         if (!ctrl_q[EN_BIT]) begin
            ctrl_q[ROLE_BIT] <= WDATA[ROLE_BIT];
         end
      end else if (sync_commit && !ctrl_q[AUTO_BIT]) begin
         ctrl_q[ONESHOT_BIT] <= 1'b0;
      end
   end

   // a measured sync is committed to the active divisor when updating is on
   assign sync_commit = sync_ok && (ctrl_q[AUTO_BIT] || ctrl_q[ONESHOT_BIT]);

   // active divisor: software writes, auto update overwrites
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         rate_divisor_q <= {RESET_BYTE, RESET_BYTE};
      end else if (wr_at(RATE_HIGH_ADDR)) begin
         rate_divisor_q[15:8] <= WDATA;
      end else if (wr_at(RATE_LOW_ADDR)) begin
         rate_divisor_q[7:0] <= WDATA;
      end else if (sync_commit) begin
         rate_divisor_q <= measured;
      end
   end

   // sync field: five falling edges span eight bits; divisor = clocks/8 - 1
   assign measured = 16'(sync_cnt_q[19:3] - 17'd1);
   // allowed deviation from the current divisor
   assign tol_span = enables_q[WIDE_BIT] ?
      18'({2'b00, rate_divisor_q} * WIDE_PCT / 100) :
      18'({2'b00, rate_divisor_q} * NARROW_PCT / 100);
   assign sync_ok = (state_q == S_SYNC) && (edge_cnt_q == 3'd5) &&
      ({2'b00, measured} + tol_span >= {2'b00, rate_divisor_q}) &&
      ({2'b00, measured} <= {2'b00, rate_divisor_q} + tol_span);
   assign slave_break_end = (state_q == S_BREAK) && rx_line && !rx_prev_q;

   // slave header tracker: break, then sync measurement
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST || !ctrl_q[EN_BIT] || ctrl_q[ROLE_BIT]) begin
         state_q <= S_IDLE;
         brk_cnt_q <= '0;
         sync_cnt_q <= '0;
         edge_cnt_q <= '0;
      end else begin
         unique case (state_q)
            S_IDLE: begin
               brk_cnt_q <= rx_line ? 18'd0 : brk_cnt_q + 18'd1;
               // a break is dominant beyond eleven times the divisor in clocks
               if (!rx_line && brk_cnt_q > 18'({2'b00, rate_divisor_q} * 11)) begin
                  state_q <= S_BREAK;
               end
            end
            S_BREAK: begin
               brk_cnt_q <= brk_cnt_q + 18'd1;
               if (rx_fault_set && tcfg_q[BRKEXIT_BIT]) begin
                  state_q <= S_IDLE;
               end else if (slave_break_end) begin
                  // wide mode needs a break below 32 bits and the clock limit
                  if (enables_q[WIDE_BIT] && (brk_cnt_q >= WIDE_BREAK_CLOCKS ||
                      brk_cnt_q >=
                      18'(({2'b00, rate_divisor_q} + 18'd1) * WIDE_BREAK_BITS))) begin
                     state_q <= S_IDLE;
                  end else begin
                     state_q <= S_SYNC;
                  end
                  sync_cnt_q <= '0;
                  edge_cnt_q <= '0;
               end
            end
            S_SYNC: begin
               if (edge_cnt_q != 3'd0) begin
                  sync_cnt_q <= sync_cnt_q + 20'd1;
               end
               if (!rx_line && rx_prev_q) begin
                  edge_cnt_q <= edge_cnt_q + 3'd1;
               end
               if (edge_cnt_q == 3'd5) begin
                  state_q <= S_DONE;
               end
            end
            S_DONE: begin
               state_q <= S_IDLE;
               brk_cnt_q <= '0;
            end
         endcase
      end
   end

   // acquired divisor and sync valid status
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         acquired_rate_divisor_q <= {RESET_BYTE, RESET_BYTE};
         sync_valid_q <= 1'b0;
      end else if (state_q == S_SYNC && edge_cnt_q == 3'd5) begin
         if (sync_ok) begin
            acquired_rate_divisor_q <= measured;
         end
         if (enables_q[WIDE_BIT]) begin
            sync_valid_q <= sync_ok;
         end
      end
   end

   // receive status from the receiver's start and stop events
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST || RX_ABORT) begin
         receive_in_progress_q <= 1'b0;
      end else if (RX_START) begin
         receive_in_progress_q <= 1'b1;
      end else if (RX_STOP) begin
         receive_in_progress_q <= 1'b0;
      end
   end

   // a mismatch while transmitting
   assign mismatch_set = TX_ACTIVE && (rx_line != tx_line);

   // writable bits of the flag register
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         loopback_enable_q <= 1'b0;
         mismatch_abort_tx_q <= 1'b0;
         mismatch_abort_rx_q <= 1'b0;
      end else if (wr_at(EVENT_FLAGS_ADDR)) begin
         loopback_enable_q <= WDATA[RECV_BIT];
         mismatch_abort_tx_q <= WDATA[LEVEL_BIT];
         mismatch_abort_rx_q <= WDATA[IDLE_BIT];
      end
   end

   // sticky event flags; a hardware set wins over a software clear
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         flags_q <= RESET_BYTE;
      end else begin
         if (wr_at(EVENT_FLAGS_ADDR)) begin
            // mismatch clears by writing zero, others by writing one
            if (!WDATA[MISMATCH_BIT]) begin
               flags_q[MISMATCH_BIT] <= 1'b0;
            end
            if (WDATA[ASYNC_BIT]) flags_q[ASYNC_BIT] <= 1'b0;
            if (WDATA[BREAK_BIT]) flags_q[BREAK_BIT] <= 1'b0;
            if (WDATA[SYNC_BIT]) flags_q[SYNC_BIT] <= 1'b0;
            if (WDATA[OVF_BIT]) flags_q[OVF_BIT] <= 1'b0;
         end
         if (mismatch_set) flags_q[MISMATCH_BIT] <= 1'b1;
         if (sync_commit) flags_q[ASYNC_BIT] <= 1'b1;
         if ((ctrl_q[ROLE_BIT] && BREAK_SENT) || slave_break_end) begin
            flags_q[BREAK_BIT] <= 1'b1;
         end
         if (sync_ok) flags_q[SYNC_BIT] <= 1'b1;
         if (COUNTER_ALL_ONES) flags_q[OVF_BIT] <= 1'b1;
      end
   end

   // abort strobes for as long as a mismatch lasts
   assign TX_ABORT = mismatch_set && mismatch_abort_tx_q;
   assign RX_ABORT = mismatch_set && mismatch_abort_rx_q;
   assign BREAK_EXIT = (state_q == S_BREAK) && rx_fault_set && tcfg_q[BRKEXIT_BIT];

   // enable register
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         enables_q <= RESET_BYTE;
      end else if (wr_at(EVENT_ENABLES_ADDR)) begin
         enables_q <= WDATA;
      end
   end

   // plain data registers of the timeout block
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         tx_dominant_limit_q <= {RESET_BYTE, RESET_BYTE};
         rx_dominant_hi_q <= {RESET_BYTE, RESET_BYTE};
         stuck_clear_width_q <= {RESET_BYTE, RESET_BYTE};
         stuck_active_width_q <= RESET_BYTE;
      end else if (WR_EN) begin
         if (ADDR == TX_LIMIT_LOW_ADDR) tx_dominant_limit_q[7:0] <= WDATA;
         if (ADDR == TX_LIMIT_HIGH_ADDR) tx_dominant_limit_q[15:8] <= WDATA;
         if (ADDR == RX_LIMIT_LOW_ADDR) rx_dominant_hi_q[7:0] <= WDATA;
         if (ADDR == RX_LIMIT_HIGH_ADDR) rx_dominant_hi_q[15:8] <= WDATA;
         if (ADDR == STUCK_CLEAR_LOW_ADDR) stuck_clear_width_q[7:0] <= WDATA;
         if (ADDR == STUCK_CLEAR_HIGH_ADDR) stuck_clear_width_q[15:8] <= WDATA;
         if (ADDR == STUCK_ACTIVE_ADDR) stuck_active_width_q <= WDATA;
      end
   end

   // dominant timers count fast oscillator ticks while the line is low
   assign tx_fault_set = FAST_TICK && !tx_line && (tx_dom_cnt_q == {1'b0, tx_dominant_limit_q});
   assign rx_fault_set = FAST_TICK && !rx_line && (rx_dom_cnt_q == rx_dominant_limit);
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST || tx_line) begin
         tx_dom_cnt_q <= '0;
      end else if (FAST_TICK && tx_dom_cnt_q <= {1'b0, tx_dominant_limit_q}) begin
         tx_dom_cnt_q <= tx_dom_cnt_q + 17'd1;
      end
   end
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST || rx_line) begin
         rx_dom_cnt_q <= '0;
      end else if (FAST_TICK && rx_dom_cnt_q <= rx_dominant_limit) begin
         rx_dom_cnt_q <= rx_dom_cnt_q + 17'd1;
      end
   end

   // timeout configuration with sticky fault flags, write zero clears
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         tcfg_q <= RESET_BYTE;
      end else begin
         if (wr_at(TIMEOUT_CONFIG_ADDR)) begin
            tcfg_q <= WDATA & tcfg_q | WDATA & ~(8'h01 << RXF_BIT) & ~(8'h01 << TXF_BIT);
         end
         if (tx_fault_set) tcfg_q[TXF_BIT] <= 1'b1;
         if (rx_fault_set) tcfg_q[RXF_BIT] <= 1'b1;
      end
   end

   // stuck dominant and wake timers on slow oscillator ticks
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         stuck_cnt_q <= '0;
         stuck_q <= 1'b0;
         wake_cnt_q <= '0;
      end else if (SLOW_TICK) begin
         if (!rx_line) begin
            wake_cnt_q <= (wake_cnt_q == swake_q[3:0]) ? wake_cnt_q : wake_cnt_q + 4'd1;
            stuck_cnt_q <= stuck_q ? 16'd0 :
               (stuck_cnt_q == {8'h00, stuck_active_width_q}) ? 16'd0 : stuck_cnt_q + 16'd1;
            if (stuck_cnt_q == {8'h00, stuck_active_width_q}) stuck_q <= 1'b1;
         end else begin
            wake_cnt_q <= '0;
            stuck_cnt_q <= stuck_q ? ((stuck_cnt_q == stuck_clear_width_q) ? 16'd0 :
               stuck_cnt_q + 16'd1) : 16'd0;
            if (stuck_q && stuck_cnt_q == stuck_clear_width_q) stuck_q <= 1'b0;
         end
      end
   end

   // wake configuration, flags sticky and cleared by writing zero
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         swake_q <= RESET_BYTE;
      end else begin
         if (wr_at(STUCK_WAKE_ADDR)) begin
            swake_q <= WDATA & (swake_q | 8'h3f);
         end
         if (SLOW_TICK && !rx_line && wake_cnt_q + 4'd1 == swake_q[3:0] + 4'd1 &&
             wake_cnt_q != swake_q[3:0] + 4'd1) begin
            swake_q[WF_BIT] <= 1'b1;
         end
         if (SLOW_TICK && !rx_line && !stuck_q &&
             stuck_cnt_q == {8'h00, stuck_active_width_q}) begin
            swake_q[SWF_BIT] <= 1'b1;
         end
      end
   end

   // interrupt requests
   // global enable gates the mismatch request and the four event requests
   assign BUS_IRQ = enables_q[GLOBAL_BIT] &&
      ((|(flags_q[3:0] & enables_q[3:0])) ||
      (flags_q[MISMATCH_BIT] && enables_q[MISMATCH_BIT]));
   assign FAULT_IRQ = (tcfg_q[TXF_BIT] && tcfg_q[TXEN_BIT]) || (tcfg_q[RXF_BIT] && tcfg_q[RXEN_BIT]);
   assign WAKE_IRQ = (swake_q[WF_BIT] && swake_q[WEN_BIT]) || (swake_q[SWF_BIT] && swake_q[SWEN_BIT]);

   // read data, one cycle after the strobe
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         rdata_q <= RESET_BYTE;
      end else if (RD_EN) begin
         unique case (ADDR)
            CONTROL_ADDR: rdata_q <= {ctrl_q[7:6], 6'h00};
            RATE_HIGH_ADDR: rdata_q <= acquired_rate_divisor_q[15:8];
            RATE_LOW_ADDR: rdata_q <= acquired_rate_divisor_q[7:0];
            EVENT_FLAGS_ADDR: rdata_q <= {receive_in_progress_q, flags_q[MISMATCH_BIT],
               rx_pin_q, !ctrl_q[EN_BIT] || (state_q == S_IDLE && !TX_ACTIVE &&
               !receive_in_progress_q), flags_q[3:0]};
            EVENT_ENABLES_ADDR: rdata_q <= {enables_q[7:5], sync_valid_q, enables_q[3:0]};
            TIMEOUT_CONFIG_ADDR: rdata_q <= tcfg_q;
            TX_LIMIT_LOW_ADDR: rdata_q <= tx_dominant_limit_q[7:0];
            TX_LIMIT_HIGH_ADDR: rdata_q <= tx_dominant_limit_q[15:8];
            RX_LIMIT_LOW_ADDR: rdata_q <= rx_dominant_hi_q[7:0];
            RX_LIMIT_HIGH_ADDR: rdata_q <= rx_dominant_hi_q[15:8];
            STUCK_CLEAR_LOW_ADDR: rdata_q <= stuck_clear_width_q[7:0];
            STUCK_CLEAR_HIGH_ADDR: rdata_q <= stuck_clear_width_q[15:8];
            STUCK_WAKE_ADDR: rdata_q <= swake_q;
            STUCK_ACTIVE_ADDR: rdata_q <= stuck_active_width_q;
            default: rdata_q <= RESET_BYTE;
         endcase
      end
   end
   assign RDATA = rdata_q;

   // flag set by a mismatch stays until software clears it
   property p_mismatch_sticky;
      @(posedge CORE_CLK) disable iff (SYS_RST)
      mismatch_set |=> flags_q[MISMATCH_BIT];
   endproperty
   a_mismatch_sticky: assert property (p_mismatch_sticky) else $error("mismatch flag lost");
   property p_sync_flag;
      @(posedge CORE_CLK) disable iff (SYS_RST)
      sync_ok |=> flags_q[SYNC_BIT] && acquired_rate_divisor_q == $past(measured);
   endproperty
   a_sync_flag: assert property (p_sync_flag) else $error("sync not stored");
   property p_auto_copy;
      @(posedge CORE_CLK) disable iff (SYS_RST)
      sync_commit && !WR_EN |=> rate_divisor_q == acquired_rate_divisor_q;
   endproperty
   a_auto_copy: assert property (p_auto_copy) else $error("divisor not updated");
   property p_polarity;
      @(posedge CORE_CLK) disable iff (SYS_RST)
      TXD_PIN == (TX_BIT ^ enables_q[POL_BIT]);
   endproperty
   a_polarity: assert property (p_polarity) else $error("transmit polarity wrong");
   property p_irq_gate;
      @(posedge CORE_CLK) disable iff (SYS_RST)
      BUS_IRQ == (enables_q[GLOBAL_BIT] &&
         (|(flags_q & enables_q & ((8'h01 << MISMATCH_BIT) | 8'h0f))));
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("interrupt not gated");
   property p_tx_fault;
      @(posedge CORE_CLK) disable iff (SYS_RST)
      tx_fault_set |=> tcfg_q[TXF_BIT];
   endproperty
   a_tx_fault: assert property (p_tx_fault) else $error("tx fault flag missed");
   property p_rx_fault;
      @(posedge CORE_CLK) disable iff (SYS_RST)
      rx_fault_set |=> tcfg_q[RXF_BIT];
   endproperty
   a_rx_fault: assert property (p_rx_fault) else $error("rx fault flag missed");
   property p_oneshot;
      @(posedge CORE_CLK) disable iff (SYS_RST)
      sync_commit && !ctrl_q[AUTO_BIT] && !WR_EN |=> !ctrl_q[ONESHOT_BIT];
   endproperty
   a_oneshot: assert property (p_oneshot) else $error("one shot not cleared");
endmodule

//--- shared/lin_sync_pkg.sv
// register map, field positions and timing constants of the lin sync and fault monitor
package lin_sync_pkg;
   localparam logic [15:0] RATE_HIGH_ADDR = 16'ha093;
   localparam logic [15:0] RATE_LOW_ADDR = 16'ha094;
   localparam logic [15:0] EVENT_FLAGS_ADDR = 16'ha095;
   localparam logic [15:0] EVENT_ENABLES_ADDR = 16'ha096;
   localparam logic [15:0] TIMEOUT_CONFIG_ADDR = 16'ha0b0;
   localparam logic [15:0] TX_LIMIT_LOW_ADDR = 16'ha0b1;
   localparam logic [15:0] TX_LIMIT_HIGH_ADDR = 16'ha0b2;
   localparam logic [15:0] RX_LIMIT_LOW_ADDR = 16'ha0b3;
   localparam logic [15:0] RX_LIMIT_HIGH_ADDR = 16'ha0b4;
   localparam logic [15:0] STUCK_CLEAR_LOW_ADDR = 16'ha0b5;
   localparam logic [15:0] STUCK_CLEAR_HIGH_ADDR = 16'ha0b6;
   localparam logic [15:0] STUCK_WAKE_ADDR = 16'ha0b7;
   localparam logic [15:0] STUCK_ACTIVE_ADDR = 16'ha0b8;
   localparam logic [15:0] CONTROL_ADDR = 16'ha090;
   // event flag register bit positions
   localparam int RECV_BIT = 7;
   localparam int MISMATCH_BIT = 6;
   localparam int LEVEL_BIT = 5;
   localparam int IDLE_BIT = 4;
   localparam int ASYNC_BIT = 3;
   localparam int BREAK_BIT = 2;
   localparam int SYNC_BIT = 1;
   localparam int OVF_BIT = 0;
   // enable register bit positions
   localparam int GLOBAL_BIT = 7;
   localparam int WIDE_BIT = 5;
   localparam int POL_BIT = 4;
   // control register bit positions
   localparam int EN_BIT = 7;
   localparam int ROLE_BIT = 6;
   localparam int AUTO_BIT = 5;
   localparam int ONESHOT_BIT = 4;
   // timeout configuration bit positions
   localparam int RXLIM0_BIT = 7;
   localparam int BRKEXIT_BIT = 6;
   localparam int RXF_BIT = 3;
   localparam int TXF_BIT = 2;
   localparam int RXEN_BIT = 1;
   localparam int TXEN_BIT = 0;
   // stuck wake config bit positions
   localparam int SWF_BIT = 7;
   localparam int WF_BIT = 6;
   localparam int SWEN_BIT = 5;
   localparam int WEN_BIT = 4;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   // sync tolerance in percent, wide break limits in bits and clocks, core clock in MHz
   localparam int NARROW_PCT = 6;
   localparam int WIDE_PCT = 50;
   localparam int WIDE_BREAK_BITS = 32;
   localparam logic [17:0] WIDE_BREAK_CLOCKS = 18'd253952;
   localparam int CORE_CLK_MHZ = 200;
endpackage

//--- testbench/lin_bus_node.sv
// far lin node seen through the transceiver: wired-and bus with pull-up
module lin_bus_node (
   input wire logic txd,
   input wire logic hold_dominant,
   output logic rxd
);
   timeunit 1ns;
   timeprecision 1ns;
   // recessive by pull-up; either party pulls the bus dominant
   assign rxd = txd & ~hold_dominant;
endmodule

//--- testbench/test_lin_sync_fault_monitor.sv
// register-level tests of the lin sync and fault monitor
module test_lin_sync_fault_monitor;
   import lin_sync_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk, rst, wr, rd, tx_bit, tx_act, hold, txd, rxd, master, irq;
   logic ft, rxl, txab, rxab, fault; // oscillator ticks, receive line, aborts, fault request
   logic [3:0] pl; // start, stop, break, overflow pulses
   logic [15:0] addr, div;
   logic [7:0] wdata, rdata;
   int miscompares, cmp_count;
   lin_bus_node node (.txd(txd), .hold_dominant(hold), .rxd(rxd));
   lin_sync_fault_monitor uut (.CORE_CLK(clk), .SYS_RST(rst), .ADDR(addr),
      .WDATA(wdata), .WR_EN(wr), .RD_EN(rd), .RDATA(rdata), .RXD_PIN(rxd),
      .TX_BIT(tx_bit), .TX_ACTIVE(tx_act), .RX_START(pl[0]), .RX_STOP(pl[1]),
      .BREAK_SENT(pl[2]), .COUNTER_ALL_ONES(pl[3]), .FAST_TICK(ft),
      .SLOW_TICK(ft), .TXD_PIN(txd), .RX_LINE(rxl), .RATE_DIVISOR(div),
      .TX_ABORT(txab), .RX_ABORT(rxab), .BREAK_EXIT(), .MASTER_MODE(master),
      .BUS_IRQ(irq), .FAULT_IRQ(fault), .WAKE_IRQ());
   // 200 MHz core clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // compare and count
   task ck(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // one-cycle register write
   task wr_reg(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // one-cycle read, data checked in the following cycle
   task rd_chk(input logic [15:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      ck({8'h00, rdata}, {8'h00, e});
   endtask
   // single-cycle event pulses from the core
   task pulse(input logic [3:0] m);
      @(posedge clk);
      pl <= m;
      @(posedge clk);
      pl <= 4'h0;
   endtask
   task print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // hang guard, far beyond the few hundred cycles needed
   initial begin
      #20us;
      miscompares++;
      print_verdict();
   end
   initial begin
      {rst, wr, rd, tx_act, hold, ft, pl, addr, wdata} = '0;
      rst = 1'b1;
      tx_bit = 1'b1;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      // reset values; flags show recessive bus and idle while disabled
      for (int a = 16'ha093; a <= 16'ha0b8; a++) begin
         if (a < 16'ha097 || a > 16'ha0af)
            rd_chk(a[15:0], (a[15:0] == EVENT_FLAGS_ADDR) ? 8'h30 : RESET_BYTE);
      end
      wr_reg(16'ha0a0, 8'hff);
      rd_chk(16'ha0a0, 8'h00);
      wr_reg(TX_LIMIT_LOW_ADDR, 8'ha5);
      rd_chk(TX_LIMIT_LOW_ADDR, 8'ha5);
      $display("test reset and map done");
      wr_reg(RATE_HIGH_ADDR, 8'h12);
      wr_reg(RATE_LOW_ADDR, 8'h34);
      #1 ck(div, 16'h1234);
      rd_chk(RATE_HIGH_ADDR, 8'h00);
      wr_reg(EVENT_ENABLES_ADDR, 8'h01 << POL_BIT);
      #1 ck({15'h0, txd}, {15'h0, ~tx_bit});
      wr_reg(EVENT_ENABLES_ADDR, 8'h00);
      $display("test divisor and polarity done");
      wr_reg(CONTROL_ADDR, 8'hc0);
      wr_reg(CONTROL_ADDR, 8'h80);
      #1 ck({15'h0, master}, 16'h0001);
      wr_reg(CONTROL_ADDR, 8'h00);
      pulse(4'h4);
      rd_chk(EVENT_FLAGS_ADDR, 8'h34);
      wr_reg(EVENT_FLAGS_ADDR, 8'h01 << BREAK_BIT);
      rd_chk(EVENT_FLAGS_ADDR, 8'h30);
      pulse(4'h8);
      rd_chk(EVENT_FLAGS_ADDR, 8'h31);
      wr_reg(EVENT_FLAGS_ADDR, 8'h01 << OVF_BIT);
      pulse(4'h1);
      rd_chk(EVENT_FLAGS_ADDR, 8'hb0);
      pulse(4'h2);
      rd_chk(EVENT_FLAGS_ADDR, 8'h30);
      $display("test event flags done");
      hold <= 1'b1;
      repeat (4) @(posedge clk);
      rd_chk(EVENT_FLAGS_ADDR, 8'h10);
      wr_reg(EVENT_ENABLES_ADDR, 8'hc0);
      tx_act <= 1'b1;
      repeat (4) @(posedge clk);
      hold <= 1'b0;
      tx_act <= 1'b0;
      repeat (4) @(posedge clk);
      rd_chk(EVENT_FLAGS_ADDR, 8'h70);
      ck({15'h0, irq}, 16'h0001);
      wr_reg(EVENT_FLAGS_ADDR, 8'h00);
      rd_chk(EVENT_FLAGS_ADDR, 8'h30);
      #1 ck({15'h0, irq}, 16'h0000);
      $display("test bus level and mismatch done");
      // loopback hides the dominant pin from the mismatch check
      wr_reg(EVENT_FLAGS_ADDR, 8'h90);
      hold <= 1'b1;
      tx_act <= 1'b1;
      repeat (4) @(posedge clk);
      #1 ck({13'h0, rxl, txab, rxab}, 16'h0004);
      rd_chk(EVENT_FLAGS_ADDR, 8'h10);
      // without loopback the mismatch fires only the receive abort
      wr_reg(EVENT_FLAGS_ADDR, 8'h10);
      #1 ck({13'h0, rxl, txab, rxab}, 16'h0001);
      hold <= 1'b0;
      tx_act <= 1'b0;
      repeat (4) @(posedge clk);
      wr_reg(EVENT_FLAGS_ADDR, 8'h00);
      $display("test loopback and abort done");
      // transmit limit of three expires on the fourth fast tick
      wr_reg(TX_LIMIT_LOW_ADDR, 8'h03);
      wr_reg(TIMEOUT_CONFIG_ADDR, 8'h01);
      ft <= 1'b1;
      tx_bit <= 1'b0;
      repeat (3) @(posedge clk);
      #1 ck({15'h0, fault}, 16'h0000);
      @(posedge clk);
      #1 ck({15'h0, fault}, 16'h0001);
      ft <= 1'b0;
      tx_bit <= 1'b1;
      // zero receive limit and zero slow widths trip at the first tick
      rd_chk(TIMEOUT_CONFIG_ADDR, 8'h0d);
      rd_chk(STUCK_WAKE_ADDR, 8'hc0);
      wr_reg(TIMEOUT_CONFIG_ADDR, 8'h01);
      #1 ck({15'h0, fault}, 16'h0000);
      $display("test dominant timeouts done");
      // slave header: long break, delimiter, then the alternating sync byte
      wr_reg(RATE_HIGH_ADDR, 8'h00);
      wr_reg(RATE_LOW_ADDR, 8'h03);
      wr_reg(EVENT_ENABLES_ADDR, 8'he0);
      wr_reg(CONTROL_ADDR, 8'h90);
      hold <= 1'b1;
      repeat (60) @(posedge clk);
      hold <= 1'b0;
      repeat (10) @(posedge clk);
      // five clocks a bit measure as divisor four, inside wide tolerance
      for (int i = 0; i < 10; i++) begin
         hold <= (i % 2 == 0);
         repeat (5) @(posedge clk);
      end
      repeat (4) @(posedge clk);
      rd_chk(RATE_LOW_ADDR, 8'h04);
      ck(div, 16'h0004);
      rd_chk(EVENT_FLAGS_ADDR, 8'h3e);
      rd_chk(EVENT_ENABLES_ADDR, 8'hf0);
      wr_reg(RATE_LOW_ADDR, 8'h03);
      #1 ck(div, 16'h0003);
      $display("test sync acquisition done");
      print_verdict();
   end
endmodule
